// File: design/dmi_init.sv
// Device-side tracker of DDR2 power-up init and configuration writes.
// Assumes command pins arrive from another chip; they are synchronised here.
//
// Added by the designer: the register offsets and register access over Wishbone.
`default_nettype none
module dmi_init (
   input  wire logic        clk_i,      // 25 MHz clock
   input  wire logic        rst_i,      // Synchronous reset, high
   input  wire logic        cke_i,      // Clock-gating pin
   input  wire logic        term_i,     // termination_control pin
   input  wire logic        cs_n_i,     // Chip select, low
   input  wire logic        ras_n_i,    // Row strobe, low
   input  wire logic        cas_n_i,    // Column strobe, low
   input  wire logic        we_n_i,     // Write enable, low
   input  wire logic [2:0]  bank_i,     // bank_select
   input  wire logic [12:0] addr_i,     // Address
   input  wire logic        wb_cyc_i,   // Wishbone cycle
   input  wire logic        wb_stb_i,   // Wishbone strobe
   input  wire logic        wb_we_i,    // Wishbone write, ignored
   input  wire logic [7:0]  wb_adr_i,   // Wishbone byte address
   input  wire logic [31:0] wb_dat_i,   // Wishbone write data, ignored
   input  wire logic [3:0]  wb_sel_i,   // Wishbone byte enables
   output logic [31:0]      wb_dat_o,   // Wishbone read data
   output logic             wb_ack_o,   // Wishbone acknowledge
   output logic             ready_o,    // Init sequence complete
   output logic             seq_err_o   // Order violated
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   localparam int PW = 22;
   logic [PW-1:0] meta, pins;
   dmi_pkg::dmi_cmd_t cmd;
   logic cke, term;
   always_ff @(posedge clk_i) begin
      meta <= {cke_i, term_i, cs_n_i, ras_n_i, cas_n_i, we_n_i,
               bank_i, addr_i};
      pins <= meta;
   end
   assign cke  = pins[21];
   assign term = pins[20];
   assign cmd  = dmi_pkg::dmi_cmd_t'(pins[19:0]);
   function automatic logic is_cfg(input dmi_pkg::dmi_cmd_t c,
                                   input logic [2:0] b);
      is_cfg = {c.cs_n, c.ras_n, c.cas_n, c.we_n} == dmi_pkg::CMD_CFG
               && c.bank == b;
   endfunction
   logic cmd_nop, cmd_pre_all, cmd_ref;
   assign cmd_nop = cmd.cs_n ||
                    {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n}
                    == dmi_pkg::CMD_NOP;
   assign cmd_pre_all = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n}
                        == dmi_pkg::CMD_PRE && cmd.addr[dmi_pkg::AP_BIT];
   assign cmd_ref = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n}
                    == dmi_pkg::CMD_REF;
   // ****************************************
   // Sequence tracker
   // ****************************************
   dmi_pkg::dmi_state_t state, next_state;
   logic [7:0]  cnt, next_cnt;
   logic [7:0]  dll_cnt, next_dll_cnt;
   logic [1:0]  refs, next_refs;
   logic [12:0] main_cfg, next_main_cfg;
   logic [12:0] ext1, next_ext1, ext2, next_ext2, ext3, next_ext3;
   logic        main_valid, next_main_valid;
   logic        next_ready, next_err;
   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_dll_cnt    = (dll_cnt == 8'hFF) ? dll_cnt : dll_cnt + 8'h01;
      next_refs       = refs;
      next_main_cfg   = main_cfg;
      next_ext1       = ext1;
      next_ext2       = ext2;
      next_ext3       = ext3;
      next_main_valid = main_valid;
      if (cke && is_cfg(cmd, dmi_pkg::BANK_EXT1)) next_ext1 = cmd.addr;
      if (cke && is_cfg(cmd, dmi_pkg::BANK_EXT2)) next_ext2 = cmd.addr;
      if (cke && is_cfg(cmd, dmi_pkg::BANK_EXT3)) next_ext3 = cmd.addr;
      if (cke && is_cfg(cmd, dmi_pkg::BANK_MAIN)) begin
         next_main_cfg   = cmd.addr;
         next_main_valid = 1'b1;
      end
      case (state)
         dmi_pkg::ST_POWER: begin
            next_cnt = 8'h00;
            if (cke) next_state = dmi_pkg::ST_WAIT;
            else if (term || !cmd_nop) next_state = dmi_pkg::ST_ERROR;
         end
         dmi_pkg::ST_WAIT: begin
            if (cnt < 8'(dmi_pkg::CKE_WAIT_CYC)) next_cnt = cnt + 8'h01;
            if (!cmd_nop) begin
               if (cmd_pre_all && cnt >= 8'(dmi_pkg::CKE_WAIT_CYC))
                  next_state = dmi_pkg::ST_PRE1;
               else
                  next_state = dmi_pkg::ST_ERROR;
            end
         end
         dmi_pkg::ST_PRE1, dmi_pkg::ST_EXT2, dmi_pkg::ST_EXT3,
         dmi_pkg::ST_EXT1, dmi_pkg::ST_DLLRST, dmi_pkg::ST_PRE2,
         dmi_pkg::ST_REF, dmi_pkg::ST_MAIN, dmi_pkg::ST_CALDEF: begin
            if (!cmd_nop) begin
               next_state = dmi_pkg::ST_ERROR;
               case (state)
                  dmi_pkg::ST_PRE1:
                     if (is_cfg(cmd, dmi_pkg::BANK_EXT2))
                        next_state = dmi_pkg::ST_EXT2;
                  dmi_pkg::ST_EXT2:
                     if (is_cfg(cmd, dmi_pkg::BANK_EXT3))
                        next_state = dmi_pkg::ST_EXT3;
                  dmi_pkg::ST_EXT3:
                     if (is_cfg(cmd, dmi_pkg::BANK_EXT1) && !cmd.addr[0]
                         && cmd.addr[9:7] == dmi_pkg::CAL_EXIT)
                        next_state = dmi_pkg::ST_EXT1;
                  dmi_pkg::ST_EXT1:
                     if (is_cfg(cmd, dmi_pkg::BANK_MAIN)
                         && cmd.addr[dmi_pkg::DLL_RST_BIT]) begin
                        next_state   = dmi_pkg::ST_DLLRST;
                        next_dll_cnt = 8'h00;
                     end
                  dmi_pkg::ST_DLLRST:
                     if (cmd_pre_all) begin
                        next_state = dmi_pkg::ST_PRE2;
                        next_refs  = 2'h0;
                     end
                  dmi_pkg::ST_PRE2, dmi_pkg::ST_REF:
                     if (cmd_ref) begin
                        next_state = dmi_pkg::ST_REF;
                        if (refs != 2'h3) next_refs = refs + 2'h1;
                     end else if (state == dmi_pkg::ST_REF
                                  && refs >= 2'(dmi_pkg::REF_MIN)
                                  && is_cfg(cmd, dmi_pkg::BANK_MAIN)
                                  && !cmd.addr[dmi_pkg::DLL_RST_BIT])
                        next_state = dmi_pkg::ST_MAIN;
                  dmi_pkg::ST_MAIN:
                     if (is_cfg(cmd, dmi_pkg::BANK_EXT1)
                         && cmd.addr[9:7] == dmi_pkg::CAL_DEFAULT
                         && dll_cnt >= 8'(dmi_pkg::DLL_LOCK_CYC))
                        next_state = dmi_pkg::ST_CALDEF;
                  default:
                     if (is_cfg(cmd, dmi_pkg::BANK_EXT1)
                         && cmd.addr[9:7] == dmi_pkg::CAL_EXIT)
                        next_state = dmi_pkg::ST_CALEX;
               endcase
            end
         end
         dmi_pkg::ST_CALEX: next_state = dmi_pkg::ST_READY;
         dmi_pkg::ST_READY: next_state = dmi_pkg::ST_READY;
         dmi_pkg::ST_ERROR: next_state = dmi_pkg::ST_ERROR;
         default:           next_state = dmi_pkg::ST_ERROR;
      endcase
      next_ready = next_state == dmi_pkg::ST_READY;
      next_err   = next_state == dmi_pkg::ST_ERROR;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state      <= dmi_pkg::ST_POWER;
         cnt        <= 8'h00;
         dll_cnt    <= 8'h00;
         refs       <= 2'h0;
         main_cfg   <= dmi_pkg::MAIN_RST;
         ext1       <= 13'h0000;
         ext2       <= 13'h0000;
         ext3       <= 13'h0000;
         main_valid <= 1'b0;
         ready_o    <= 1'b0;
         seq_err_o  <= 1'b0;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         dll_cnt    <= next_dll_cnt;
         refs       <= next_refs;
         main_cfg   <= next_main_cfg;
         ext1       <= next_ext1;
         ext2       <= next_ext2;
         ext3       <= next_ext3;
         main_valid <= next_main_valid;
         ready_o    <= next_ready;
         seq_err_o  <= next_err;
      end
   end
   // ****************************************
   // Wishbone read-only register port
   // ****************************************
   logic [31:0] next_dat;
   logic        next_ack;
   logic [3:0]  burst;
   always_comb begin
      burst = (main_cfg[2:0] == dmi_pkg::BL4) ? 4'h4 :
              (main_cfg[2:0] == dmi_pkg::BL8) ? 4'h8 : 4'h0;
      next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
      case (wb_adr_i)
         dmi_pkg::ADR_MAIN:   next_dat = {19'h0, main_cfg};
         dmi_pkg::ADR_EXT1:   next_dat = {19'h0, ext1};
         dmi_pkg::ADR_EXT2:   next_dat = {19'h0, ext2};
         dmi_pkg::ADR_EXT3:   next_dat = {19'h0, ext3};
         dmi_pkg::ADR_STATUS: next_dat = {24'h0, main_valid, seq_err_o,
                                          ready_o, 1'b0, state};
         dmi_pkg::ADR_DECODE: next_dat = {16'h0, 1'b0, main_cfg[11:9],
                                          main_cfg[dmi_pkg::TEST_BIT],
                                          main_cfg[6:4], main_cfg[3],
                                          3'h0, burst};
         default:             next_dat = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_ready_order;
      @(posedge clk_i) disable iff (rst_i)
      $rose(ready_o) |-> $past(state) == dmi_pkg::ST_CALEX;
   endproperty
   a_ready_order: assert property (p_ready_order)
      else $error("ready without calibration exit");
   property p_wait;
      @(posedge clk_i) disable iff (rst_i)
      (state == dmi_pkg::ST_PRE1 && $past(state) == dmi_pkg::ST_WAIT)
         |-> $past(cke, dmi_pkg::CKE_WAIT_CYC + 2);
   endproperty
   a_wait: assert property (p_wait)
      else $error("precharge accepted too early");
   property p_cal;
      @(posedge clk_i) disable iff (rst_i)
      (state == dmi_pkg::ST_CALDEF && $past(state) == dmi_pkg::ST_MAIN)
         |-> $past(state, dmi_pkg::DLL_LOCK_CYC) != dmi_pkg::ST_EXT1;
   endproperty
   a_cal: assert property (p_cal)
      else $error("calibration before DLL lock time");
   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus ack timing wrong");
   property p_err_hold;
      @(posedge clk_i) disable iff (rst_i)
      seq_err_o |=> seq_err_o;
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("order error flag cleared");
   property p_main_cap;
      @(posedge clk_i) disable iff (rst_i)
      (cke && cmd[19:13] == {dmi_pkg::CMD_CFG, dmi_pkg::BANK_MAIN})
         |=> main_valid && main_cfg == $past(cmd.addr);
   endproperty
   a_main_cap: assert property (p_main_cap)
      else $error("main register write not captured");
endmodule
`default_nettype wire

// File: design/dmi_pkg.sv
// Package for the DDR2 device-side init and configuration-register block.
// Assumes one 25 MHz clock and a classic Wishbone register port.
`default_nettype none
package dmi_pkg;
   // ****************************************
   // Register map, byte addresses
   // ****************************************
   localparam logic [7:0] ADR_MAIN   = 8'h00;
   localparam logic [7:0] ADR_EXT1   = 8'h04;
   localparam logic [7:0] ADR_EXT2   = 8'h08;
   localparam logic [7:0] ADR_EXT3   = 8'h0C;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   localparam logic [7:0] ADR_DECODE = 8'h14;
   // ****************************************
   // Command encoding {cs_n,ras_n,cas_n,we_n}
   // ****************************************
   localparam logic [3:0] CMD_CFG  = 4'h0;
   localparam logic [3:0] CMD_PRE  = 4'h2;
   localparam logic [3:0] CMD_REF  = 4'h1;
   localparam logic [3:0] CMD_NOP  = 4'h7;
   localparam logic [2:0] BANK_MAIN = 3'h0;
   localparam logic [2:0] BANK_EXT1 = 3'h1;
   localparam logic [2:0] BANK_EXT2 = 3'h2;
   localparam logic [2:0] BANK_EXT3 = 3'h3;
   localparam int         AP_BIT    = 10;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int DLL_RST_BIT = 8;
   localparam int TEST_BIT    = 7;
   localparam logic [2:0] CAL_DEFAULT = 3'h7;
   localparam logic [2:0] CAL_EXIT    = 3'h0;
   localparam logic [2:0] BL4  = 3'h2;
   localparam logic [2:0] BL8  = 3'h3;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ        = 25;
   localparam int CKE_WAIT_NS    = 400;
   localparam int CKE_WAIT_CYC   = (CKE_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int DLL_LOCK_CYC   = 200;
   localparam int REF_MIN        = 2;
   localparam logic [12:0] MAIN_RST = 13'h0000;

   typedef enum logic [3:0] {
      ST_POWER  = 4'h0,
      ST_WAIT   = 4'h1,
      ST_PRE1   = 4'h3,
      ST_EXT2   = 4'h2,
      ST_EXT3   = 4'h6,
      ST_EXT1   = 4'h7,
      ST_DLLRST = 4'h5,
      ST_PRE2   = 4'h4,
      ST_REF    = 4'hC,
      ST_MAIN   = 4'hD,
      ST_CALDEF = 4'hF,
      ST_CALEX  = 4'hE,
      ST_READY  = 4'hA,
      ST_ERROR  = 4'hB
   } dmi_state_t;

   typedef struct packed {
      logic       cs_n;
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic [2:0] bank;
      logic [12:0] addr;
   } dmi_cmd_t;
endpackage
`default_nettype wire

// File: dv/dmi_ctrl_model.sv
// Behavioural DDR2 controller that drives the command pins of dmi_init.
// Assumes the bench owns the clock and calls run_init or stray_term after each reset.
`default_nettype none
module dmi_ctrl_model #(
   parameter logic [12:0] MAIN_VAL = 13'h0232,
   parameter logic [12:0] EXT1_VAL = 13'h0004,
   parameter logic [12:0] EXT2_VAL = 13'h0080
) (
   input  wire logic         clk_i,  // Bench clock
   output logic              cke_o,  // Clock-gating pin
   output logic              term_o, // termination_control pin
   output dmi_pkg::dmi_cmd_t cmd_o   // Command, bank and address
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GAP = 2;
   initial begin
      cke_o  = 1'b0;
      term_o = 1'b0;
      cmd_o  = {dmi_pkg::CMD_NOP, 3'h0, 13'h0000};
   end
   // idle NOP gap
   // Idle pins toggle so the device never sees a stale command field.
   task automatic issue(input logic [3:0] c, input logic [2:0] b,
                        input logic [12:0] a, input int gap);
      @(posedge clk_i);
      cmd_o <= {c, b, a};
      repeat (gap) begin
         @(posedge clk_i);
         cmd_o <= {dmi_pkg::CMD_NOP, ~cmd_o.bank, ~cmd_o.addr};
      end
   endtask
   task automatic drop();
      @(posedge clk_i);
      cke_o <= 1'b0;
   endtask
   task automatic stray_term();
      @(posedge clk_i);
      term_o <= 1'b1;
      @(posedge clk_i);
      term_o <= 1'b0;
   endtask
   task automatic run_init(input bit skip3, input int lock, input int nref);
      int t;
      issue(dmi_pkg::CMD_NOP, 3'h0, 13'h0000, 4);
      cke_o <= 1'b1;
      // 560 ns of NOP, precharge all
      issue(dmi_pkg::CMD_NOP, 3'h0, 13'h0000, dmi_pkg::CKE_WAIT_CYC + 2);
      issue(dmi_pkg::CMD_PRE, 3'h0, 13'h0400, GAP);
      issue(dmi_pkg::CMD_CFG, dmi_pkg::BANK_EXT2, EXT2_VAL, GAP);
      if (!skip3) issue(dmi_pkg::CMD_CFG, dmi_pkg::BANK_EXT3, 13'h0000, GAP);
      issue(dmi_pkg::CMD_CFG, dmi_pkg::BANK_EXT1, EXT1_VAL, GAP);
      issue(dmi_pkg::CMD_CFG, dmi_pkg::BANK_MAIN, MAIN_VAL | 13'h0100, GAP);
      t = GAP;
      issue(dmi_pkg::CMD_PRE, 3'h0, 13'h0400, GAP);
      for (int i = 0; i < nref; i++) begin
         issue(dmi_pkg::CMD_REF, 3'h0, 13'h0000, GAP);
         t += GAP + 1;
      end
      issue(dmi_pkg::CMD_CFG, dmi_pkg::BANK_MAIN, MAIN_VAL, GAP);
      t += 2 * GAP + 2;
      while (t < lock) begin
         @(posedge clk_i);
         t++;
      end
      issue(dmi_pkg::CMD_CFG, dmi_pkg::BANK_EXT1, EXT1_VAL | 13'h0380, GAP);
      issue(dmi_pkg::CMD_CFG, dmi_pkg::BANK_EXT1, EXT1_VAL, GAP);
   endtask
endmodule
`default_nettype wire

// File: dv/dmi_init_tb_top.sv
// Self-checking bench for dmi_init: controller model on the pins,
// Wishbone reads of the captured registers and status.
`default_nettype none
module dmi_init_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [12:0] MAIN_VAL = 13'h0232;
   localparam logic [12:0] MAIN_NEW = 13'h0643;
   typedef struct {logic [7:0] adr; logic [31:0] exp;} dmi_row_t;
   typedef struct {bit skip; int lock; int nref;} dmi_bad_t;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              wb_cyc_i = 1'b0;
   logic              wb_stb_i = 1'b0;
   logic              wb_we_i = 1'b0;
   logic [7:0]        wb_adr_i = 8'h00;
   logic [31:0]       wb_dat_i = 32'h0000_0000;
   logic [3:0]        wb_sel_i = 4'hF;
   logic [31:0]       wb_dat_o;
   logic              wb_ack_o, ready_o, seq_err_o, cke, term;
   dmi_pkg::dmi_cmd_t cmd;
   int                errors = 0;
   int                comparisons = 0;
   always #20 clk_i = ~clk_i;
   dmi_ctrl_model #(.MAIN_VAL(MAIN_VAL)) i_ctrl (.clk_i(clk_i), .cke_o(cke),
      .term_o(term), .cmd_o(cmd));
   dmi_init i_dut (.clk_i(clk_i), .rst_i(rst_i), .cke_i(cke), .term_i(term),
      .cs_n_i(cmd.cs_n), .ras_n_i(cmd.ras_n), .cas_n_i(cmd.cas_n),
      .we_n_i(cmd.we_n), .bank_i(cmd.bank), .addr_i(cmd.addr),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ready_o(ready_o),
      .seq_err_o(seq_err_o));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Holds the request until ack is seen at a rising edge.
   task automatic bus(input logic we, input logic [7:0] adr,
                      output logic [31:0] rd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= 32'hFFFF_FFFF;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic do_reset();
      i_ctrl.drop();
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic test_done();
      $display("Comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      $display("Error at %0t: watchdog expired", $time);
      test_done();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] rd;
      dmi_row_t rows[7];
      dmi_bad_t bad[3];
      rows = '{'{dmi_pkg::ADR_MAIN, 32'h0000_0232},
               '{dmi_pkg::ADR_EXT1, 32'h0000_0004},
               '{dmi_pkg::ADR_EXT2, 32'h0000_0080},
               '{dmi_pkg::ADR_EXT3, 32'h0000_0000},
               '{dmi_pkg::ADR_STATUS, 32'h0000_00AA},
               '{dmi_pkg::ADR_DECODE, 32'h0000_1304},
               '{8'h18, 32'h0000_0000}};
      bad = '{'{1'b1, 210, 2}, '{1'b0, 40, 2}, '{1'b0, 210, 1}};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, dmi_pkg::ADR_STATUS, rd);
      check(rd, 32'h0, "status after reset");
      check({30'h0, ready_o, seq_err_o}, 32'h0, "flags after reset");
      $display("Test reset done");
      i_ctrl.run_init(1'b0, 210, 2);
      repeat (4) @(posedge clk_i);
      check({31'h0, ready_o}, 32'h1, "ready after init");
      foreach (rows[i]) begin
         bus(1'b0, rows[i].adr, rd);
         check(rd, rows[i].exp, "register read");
      end
      bus(1'b1, dmi_pkg::ADR_MAIN, rd);
      bus(1'b0, dmi_pkg::ADR_MAIN, rd);
      check(rd, {19'h0, MAIN_VAL}, "main after bus write");
      $display("Test init done");
      i_ctrl.issue(dmi_pkg::CMD_PRE, 3'h0, 13'h0400, 2);
      i_ctrl.issue(dmi_pkg::CMD_CFG, dmi_pkg::BANK_MAIN, MAIN_NEW, 2);
      repeat (4) @(posedge clk_i);
      bus(1'b0, dmi_pkg::ADR_MAIN, rd);
      check(rd, {19'h0, MAIN_NEW}, "main rewrite");
      bus(1'b0, dmi_pkg::ADR_DECODE, rd);
      check(rd, 32'h0000_3408, "decode rewrite");
      check({31'h0, ready_o}, 32'h1, "ready kept");
      $display("Test rewrite done");
      foreach (bad[i]) begin
         do_reset();
         i_ctrl.run_init(bad[i].skip, bad[i].lock, bad[i].nref);
         repeat (4) @(posedge clk_i);
         check({30'h0, ready_o, seq_err_o}, 32'h1, "bad order");
      end
      $display("Test order faults done");
      do_reset();
      i_ctrl.stray_term();
      repeat (4) @(posedge clk_i);
      check({30'h0, ready_o, seq_err_o}, 32'h1, "early term");
      bus(1'b0, dmi_pkg::ADR_STATUS, rd);
      check(rd, 32'h0000_004B, "status after fault");
      $display("Test termination done");
      test_done();
   end
endmodule
`default_nettype wire
